// File: verilog/output_step_list_sequencer.sv
// module: output step-list sequencer with trigger pins
// Behaviour
// [R01] list holds up to 100 steps, each with voltage and current setpoint
// [R02] insert goes after selected step, copying the preceding step's fields
// [R03] delete removes selected step only; clear empties whole list
// [R04] each step has run time in seconds, its dwell in dwell pacing
// [R05] start-of-step flag emits trigger out as the step begins
// [R06] end-of-step flag emits trigger out as the step finishes
// [R07] return-to-DC default restores prior setpoints on completion
// [R08] hold setting keeps final step setpoints after completion
// [R09] dwell pacing applies next step once dwell time elapses
// [R10] trigger pacing advances on trigger; holds step while waiting
// [R11] each trigger-output pin has its own independent polarity
// [R12] each trigger event drives a 10 us pulse on trigger-output pins
// [R13] positive polarity pulses high from common; negative pulses low
// [R14] input trigger on rising or falling edge by polarity; 2 us minimum
// [R15] list runs repeat count times, 1 to 256, default 1
// [R16] steps run in order; start event precedes new setpoints
`timescale 1ns/1ps
`default_nettype none
module output_step_list_sequencer
	import step_list_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// list editing
	input wire step_list_pkg::edit_e edit_cmd,
	input wire logic [step_list_pkg::IDX_W-1:0] edit_sel,
	input wire logic [step_list_pkg::SET_W-1:0] edit_volt,
	input wire logic [step_list_pkg::SET_W-1:0] edit_curr,
	input wire logic [step_list_pkg::TIME_W-1:0] edit_time,
	input wire logic edit_start_of_step_trigger_flag,
	input wire logic edit_end_of_step_trigger_flag,
	// run control and configuration
	input wire logic run_start,
	input wire logic run_abort,
	input wire logic after_hold,
	input wire logic pace_trigger,
	input wire logic [step_list_pkg::RPT_W-1:0] repeat_minus1,
	input wire logic [step_list_pkg::SET_W-1:0] dc_volt,
	input wire logic [step_list_pkg::SET_W-1:0] dc_curr,
	// digital pins
	input wire logic [step_list_pkg::PIN_N-1:0] pin_in,
	input wire logic [step_list_pkg::PIN_N-1:0] pin_trig_in_en,
	input wire logic [step_list_pkg::PIN_N-1:0] pin_trig_out_en,
	input wire logic [step_list_pkg::PIN_N-1:0] pin_negative,
	output logic [step_list_pkg::PIN_N-1:0] pin_out,
	output logic [step_list_pkg::PIN_N-1:0] pin_oe,
	// status and setpoints
	output logic [step_list_pkg::IDX_W-1:0] step_count,
	output logic running,
	output logic [step_list_pkg::IDX_W-1:0] step_index,
	output logic [step_list_pkg::SET_W-1:0] volt_set,
	output logic [step_list_pkg::SET_W-1:0] curr_set
);
	import step_list_pkg::*;

	// ========================================
	// step storage
	typedef struct packed {
		logic [SET_W-1:0] volt;
		logic [SET_W-1:0] curr;
		logic [TIME_W-1:0] secs;
		logic start_of_step_trigger_flag;
		logic end_of_step_trigger_flag;
	} step_s;
	step_s list_q [MAX_STEPS];
	step_s list_d [MAX_STEPS];
	logic [IDX_W-1:0] count_q, count_d;
	logic editable;
	logic sel_ok;

	assign editable = !running;
	assign sel_ok = edit_sel < count_q;

	// [R01] [R02] [R03] list editing
	always_comb begin
		list_d = list_q;
		count_d = count_q;
		if (editable) begin
			case (edit_cmd)
				EDIT_INSERT: begin
					if (count_q < IDX_W'(MAX_STEPS)) begin
						// tail moves up; new step at edit_sel+1 copies step edit_sel
						for (int i = MAX_STEPS - 1; i > 0; i--) begin
							if (IDX_W'(i) > edit_sel && IDX_W'(i) <= count_q) begin
								list_d[i] = list_q[i-1];
							end
						end
						count_d = count_q + 7'h01;
					end
				end
				EDIT_DELETE: begin
					if (sel_ok) begin
						for (int i = 0; i < MAX_STEPS - 1; i++) begin
							if (IDX_W'(i) >= edit_sel) begin
								list_d[i] = list_q[i+1];
							end
						end
						count_d = count_q - 7'h01;
					end
				end
				EDIT_CLEAR: begin
					count_d = COUNT_RST;
				end
				EDIT_WRITE: begin
					if (sel_ok) begin
						list_d[edit_sel] = {edit_volt, edit_curr, edit_time,
							edit_start_of_step_trigger_flag, edit_end_of_step_trigger_flag};
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < MAX_STEPS; i++) begin
				list_q[i] <= '0;
			end
			count_q <= COUNT_RST;
		end else begin
			list_q <= list_d;
			count_q <= count_d;
		end
	end

	// ========================================
	// trigger input sampling
	logic [PIN_N-1:0] in_s1_q, in_s2_q, in_s3_q;
	logic trig_in;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_s1_q <= '0;
			in_s2_q <= '0;
			in_s3_q <= '0;
		end else begin
			in_s1_q <= pin_in;
			in_s2_q <= in_s1_q;
			in_s3_q <= in_s2_q;
		end
	end

	// [R14] polarity-selected edge
	assign trig_in = |(pin_trig_in_en &
		((~pin_negative & in_s2_q & ~in_s3_q) | (pin_negative & ~in_s2_q & in_s3_q)));

	// ========================================
	// sequencer
	seq_e state_q, state_d;
	logic [IDX_W-1:0] idx_q, idx_d;
	logic [RPT_W-1:0] pass_q, pass_d;
	logic [TIME_W-1:0] secs_q, secs_d;
	logic [SEC_W-1:0] tick_q, tick_d;
	logic [SET_W-1:0] volt_q2, volt_d2, curr_q2, curr_d2;
	logic [SET_W-1:0] save_v_q, save_v_d, save_c_q, save_c_d;
	logic fire, held_q, held_d;
	logic last_step;
	logic sec_tick;

	assign last_step = idx_q == count_q - 7'h01;
	assign sec_tick = tick_q == SEC_W'(SECOND_CYC - 1);

	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		pass_d = pass_q;
		secs_d = secs_q;
		tick_d = tick_q;
		volt_d2 = volt_q2;
		curr_d2 = curr_q2;
		save_v_d = save_v_q;
		save_c_d = save_c_q;
		held_d = held_q;
		fire = 1'b0;
		case (state_q)
			ST_IDLE: begin
				volt_d2 = held_q ? volt_q2 : dc_volt;
				curr_d2 = held_q ? curr_q2 : dc_curr;
				if (run_start && count_q != COUNT_RST) begin
					held_d = 1'b0;
					save_v_d = volt_q2;
					save_c_d = curr_q2;
					idx_d = COUNT_RST;
					pass_d = REPEAT_RST;
					state_d = ST_START;
				end
			end
			ST_START: begin
				// [R05] [R16] start trigger before setpoint change
				fire = list_q[idx_q].start_of_step_trigger_flag;
				state_d = ST_RUN;
			end
			ST_RUN: begin
				// [R04] [R16] apply step then time it in seconds
				volt_d2 = list_q[idx_q].volt;
				curr_d2 = list_q[idx_q].curr;
				tick_d = sec_tick ? '0 : tick_q + 24'h000001;
				secs_d = sec_tick ? secs_q + 24'h000001 : secs_q;
				// [R09] [R10] pacing selects the advance cause
				if (pace_trigger ? trig_in : (secs_q >= list_q[idx_q].secs)) begin
					state_d = ST_END;
				end else if (pace_trigger && secs_q >= list_q[idx_q].secs) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// [R10] hold values until trigger
				if (trig_in) begin
					state_d = ST_END;
				end
			end
			ST_END: begin
				// [R06] end trigger
				fire = list_q[idx_q].end_of_step_trigger_flag;
				secs_d = '0;
				tick_d = '0;
				state_d = ST_START;
				if (last_step) begin
					idx_d = COUNT_RST;
					// [R15] repeat count
					if (pass_q == repeat_minus1) begin
						state_d = ST_IDLE;
						// [R07] [R08] after-list action
						held_d = after_hold;
						if (after_hold == AFTER_DC) begin
							volt_d2 = save_v_q;
							curr_d2 = save_c_q;
						end
					end else begin
						pass_d = pass_q + 8'h01;
					end
				end else begin
					idx_d = idx_q + 7'h01;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (run_abort && state_q != ST_IDLE) begin
			state_d = ST_IDLE;
			held_d = 1'b1;
			secs_d = '0;
			tick_d = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			idx_q <= COUNT_RST;
			pass_q <= REPEAT_RST;
			secs_q <= '0;
			tick_q <= '0;
			volt_q2 <= '0;
			curr_q2 <= '0;
			save_v_q <= '0;
			save_c_q <= '0;
			held_q <= 1'b0;
			running <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			pass_q <= pass_d;
			secs_q <= secs_d;
			tick_q <= tick_d;
			volt_q2 <= volt_d2;
			curr_q2 <= curr_d2;
			save_v_q <= save_v_d;
			save_c_q <= save_c_d;
			held_q <= held_d;
			running <= state_d != ST_IDLE;
		end
	end

	// ========================================
	// trigger output pulse
	logic [PULSE_W-1:0] pulse_q, pulse_d;
	logic [PIN_N-1:0] out_d;

	always_comb begin
		// [R12] 10 us pulse, retriggerable
		pulse_d = fire ? PULSE_W'(PULSE_CYC) : (pulse_q != '0 ? pulse_q - 8'h01 : pulse_q);
		// [R11] [R13] per-pin polarity
		out_d = pin_negative ^ {PIN_N{pulse_d != '0}};
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulse_q <= '0;
			pin_out <= '0;
			pin_oe <= '0;
			step_count <= COUNT_RST;
			step_index <= COUNT_RST;
			volt_set <= '0;
			curr_set <= '0;
		end else begin
			pulse_q <= pulse_d;
			pin_out <= out_d & pin_trig_out_en;
			pin_oe <= pin_trig_out_en;
			step_count <= count_d;
			step_index <= idx_d;
			volt_set <= volt_d2;
			curr_set <= curr_d2;
		end
	end

	// ========================================
	// checks
	// [R12] pulse length
	a_pulse_len: assert property (@(posedge clock) disable iff (!rst_n) fire |=> pulse_q == PULSE_W'(PULSE_CYC)) // [R12]
		else $error("trigger pulse length wrong");
	// [R16] start precedes setpoint
	a_start_order: assert property (@(posedge clock) disable iff (!rst_n) state_q == ST_START && !run_abort |=> state_q == ST_RUN) // [R16]
		else $error("start event not followed by run");
	// [R03] clear empties list
	a_clear_list: assert property (@(posedge clock) disable iff (!rst_n) edit_cmd == EDIT_CLEAR && editable |=> step_count == COUNT_RST) // [R03]
		else $error("clear did not empty list");
	// [R01] list bound
	a_list_bound: assert property (@(posedge clock) disable iff (!rst_n) count_q <= IDX_W'(MAX_STEPS)) // [R01]
		else $error("list exceeds capacity");
	// [R10] wait holds voltage setpoint
	a_wait_hold: assert property (@(posedge clock) disable iff (!rst_n) state_q == ST_WAIT |=> $stable(volt_q2)) // [R10]
		else $error("setpoint moved while waiting");
	// [R07] return to dc
	a_return_dc: assert property (@(posedge clock) disable iff (!rst_n) state_q == ST_END && last_step && pass_q == repeat_minus1 && !after_hold && !run_abort |=> volt_q2 == $past(save_v_q)) // [R07]
		else $error("dc value not restored");
	// [R13] idle level
	a_idle_level: assert property (@(posedge clock) disable iff (!rst_n) pulse_q == '0 && $past(rst_n) |-> pin_out == (pin_negative & pin_trig_out_en) || $changed(pin_negative) || $changed(pin_trig_out_en)) // [R13]
		else $error("idle trigger level wrong");
	// [R02] insert grows list
	a_insert_grow: assert property (@(posedge clock) disable iff (!rst_n) edit_cmd == EDIT_INSERT && editable && count_q < IDX_W'(MAX_STEPS) |=> count_q == $past(count_q) + 7'h01) // [R02]
		else $error("insert did not grow list");
endmodule : output_step_list_sequencer
`default_nettype wire

// File: verilog/step_list_pkg.sv
// package: constants for the output step-list sequencer
package step_list_pkg;
	// ========================================
	// list geometry
	localparam int MAX_STEPS = 100;
	localparam int IDX_W = 7;
	localparam int SET_W = 16;
	localparam int TIME_W = 24;
	localparam int PIN_N = 4;
	localparam int RPT_W = 8;
	// ========================================
	// timing
	localparam int CLOCK_HZ = 10000000;
	localparam int TICK_US = 1000000;
	localparam int PULSE_TIME_US = 10;
	localparam int PULSE_CYC = (PULSE_TIME_US * CLOCK_HZ) / TICK_US;
	localparam int SECOND_CYC = CLOCK_HZ;
	localparam int PULSE_W = 8;
	localparam int SEC_W = 24;
	// ========================================
	// reset values
	localparam logic [IDX_W-1:0] COUNT_RST = 7'h00;
	localparam logic [RPT_W-1:0] REPEAT_RST = 8'h00;
	localparam logic AFTER_DC = 1'b0;
	localparam logic AFTER_HOLD = 1'b1;
	localparam logic PACE_DWELL = 1'b0;
	localparam logic PACE_TRIG = 1'b1;
	// ========================================
	// edit commands
	typedef enum logic [3:0] {
		EDIT_NONE = 4'h0,
		EDIT_INSERT = 4'h1,
		EDIT_DELETE = 4'h2,
		EDIT_CLEAR = 4'h4,
		EDIT_WRITE = 4'h8
	} edit_e;
	// ========================================
	// sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_RUN = 5'h04,
		ST_WAIT = 5'h08,
		ST_END = 5'h10
	} seq_e;
endpackage : step_list_pkg

// File: bench/trig_gear.sv
// model of external trigger equipment on one digital pin
`timescale 1ns/1ps
`default_nettype none
module trig_gear (
	// clock
	input wire logic clock,
	// pin side
	input wire logic wire_lvl,
	input wire logic neg,
	input wire logic fire,
	output logic drv,
	// observations
	output int pulses,
	output int width
);
	int run_q;
	int hold_q;
	initial begin
		pulses = 0;
		width = 0;
		run_q = 0;
		hold_q = 0;
	end
	assign drv = (hold_q > 0) ^ neg;
	always @(posedge clock) begin
		if (fire)
			hold_q <= 25;
		else if (hold_q > 0)
			hold_q <= hold_q - 1;
		if (wire_lvl ^ neg)
			run_q <= run_q + 1;
		else if (run_q > 0) begin
			pulses <= pulses + 1;
			width <= run_q;
			run_q <= 0;
		end
	end
endmodule : trig_gear
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the step-list sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin \
	num_checks++; \
	if ((ex) !== (ac)) begin \
		err_total++; \
		$display("ERROR %s expected %h seen %h", nm, ex, ac); \
	end \
end
module tb_top;
	import step_list_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	edit_e edit_cmd = EDIT_NONE;
	logic [IDX_W-1:0] edit_sel = '0, step_count, step_index;
	logic [SET_W-1:0] edit_volt = '0, edit_curr = '0, volt_set, curr_set;
	logic [SET_W-1:0] dc_volt = 16'h1F0F, dc_curr = 16'h0A0A;
	logic [TIME_W-1:0] edit_time = '0;
	logic start_flag = 0, end_flag = 0, run_start = 0, run_abort = 0;
	logic after_hold = 0, pace_trigger = 0;
	logic running;
	logic [RPT_W-1:0] repeat_minus1 = '0;
	logic [PIN_N-1:0] pin_trig_in_en = 4'h9, pin_trig_out_en = 4'h6, pin_negative = 4'h3;
	logic [PIN_N-1:0] pin_out, pin_oe, fire = '0;
	wire [PIN_N-1:0] drv, pin_wire;
	int pulses[PIN_N], width[PIN_N];
	int err_total = 0, num_checks = 0, seed = 97866;
	logic [31:0] exp_q[$];
	logic [31:0] prev, mon_exp;
	logic [31:0] sv[3];
	// ========================================
	// clock, design and pin partners
	always #50 clock = ~clock;
	output_step_list_sequencer uut (.clock(clock), .rst_n(rst_n), .edit_cmd(edit_cmd),
		.edit_sel(edit_sel), .edit_volt(edit_volt), .edit_curr(edit_curr),
		.edit_time(edit_time), .edit_start_of_step_trigger_flag(start_flag),
		.edit_end_of_step_trigger_flag(end_flag),
		.run_start(run_start), .run_abort(run_abort), .after_hold(after_hold),
		.pace_trigger(pace_trigger), .repeat_minus1(repeat_minus1), .dc_volt(dc_volt),
		.dc_curr(dc_curr), .pin_in(pin_wire), .pin_trig_in_en(pin_trig_in_en),
		.pin_trig_out_en(pin_trig_out_en), .pin_negative(pin_negative), .pin_out(pin_out),
		.pin_oe(pin_oe), .step_count(step_count), .running(running),
		.step_index(step_index), .volt_set(volt_set), .curr_set(curr_set));
	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		assign pin_wire[i] = pin_oe[i] ? pin_out[i] : drv[i];
		trig_gear gear (.clock(clock), .wire_lvl(pin_wire[i]), .neg(pin_negative[i]),
			.fire(fire[i]), .drv(drv[i]), .pulses(pulses[i]), .width(width[i]));
	end
	// ========================================
	// setpoint monitor against expected queue
	always @(negedge clock) begin
		if (rst_n === 1'b1 && {volt_set, curr_set} !== prev) begin
			if (exp_q.size() == 0) begin
				`CHK("extra setpoint", prev, {volt_set, curr_set})
			end else begin
				mon_exp = exp_q.pop_front();
				`CHK("setpoint", mon_exp, {volt_set, curr_set})
			end
		end
		prev = {volt_set, curr_set};
	end
	// ========================================
	// tasks
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : tick
	task automatic edit(edit_e c, int s, logic [31:0] vc, logic b, logic e);
		edit_cmd = c;
		edit_sel = IDX_W'(s);
		{edit_volt, edit_curr} = vc;
		start_flag = b;
		end_flag = e;
		tick(1);
		edit_cmd = EDIT_NONE;
		tick(1);
	endtask : edit
	task automatic build(logic [2:0] b, logic [2:0] e);
		edit(EDIT_CLEAR, 0, 0, 0, 0);
		for (int k = 0; k < 3; k++) begin
			sv[k] = $random(seed);
			sv[k][19:16] = 4'(k);
			edit(EDIT_INSERT, (k > 0) ? k - 1 : 0, 0, 0, 0);
			edit(EDIT_WRITE, k, sv[k], b[k], e[k]);
		end
	endtask : build
	task automatic run(logic hold, logic pace, logic [7:0] rpt);
		after_hold = hold;
		pace_trigger = pace;
		repeat_minus1 = rpt;
		for (int p = 0; p <= rpt; p++)
			for (int k = 0; k < 3; k++)
				exp_q.push_back(sv[k]);
		if (!hold)
			exp_q.push_back({dc_volt, dc_curr});
		run_start = 1;
		tick(1);
		run_start = 0;
	endtask : run
	task automatic wait_idle();
		int n;
		n = 0;
		tick(3);
		while (running !== 1'b0 && n < 3000) begin
			tick(1);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			end_of_test();
		end
		tick(5);
		`CHK("queue drained", 0, exp_q.size())
	endtask : wait_idle
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// ========================================
	// main sequence
	initial begin
		exp_q.push_back({dc_volt, dc_curr});
		tick(4);
		rst_n = 1;
		tick(2);
		`CHK("count after reset", COUNT_RST, step_count)
		run_start = 1;
		tick(1);
		run_start = 0;
		tick(3);
		`CHK("empty list start", 1'b0, running)
		for (int k = 0; k < 101; k++)
			edit(EDIT_INSERT, 0, 0, 0, 0);
		`CHK("full list", 7'h64, step_count)
		edit(EDIT_DELETE, 100, 0, 0, 0);
		`CHK("delete beyond", 7'h64, step_count)
		edit(EDIT_DELETE, 5, 0, 0, 0);
		`CHK("delete one", 7'h63, step_count)
		edit(EDIT_CLEAR, 0, 0, 0, 0);
		`CHK("clear", 7'h00, step_count)
		$display("test edit done");
		build(3'b000, 3'b000);
		edit(EDIT_INSERT, 1, 0, 0, 0);
		`CHK("insert count", 7'h04, step_count)
		run(0, 0, 8'h01);
		wait_idle();
		$display("test dwell done");
		build(3'b001, 3'b010);
		run(1, 1, 8'h00);
		tick(300);
		`CHK("index held", 7'h00, step_index)
		for (int k = 0; k < 3; k++) begin
			fire = (k == 1) ? 4'h8 : 4'h1;
			tick(1);
			fire = '0;
			tick(300);
		end
		wait_idle();
		`CHK("pin enable", 4'h6, pin_oe)
		`CHK("neg pulses", 2, pulses[1])
		`CHK("pos pulses", 2, pulses[2])
		`CHK("neg width", PULSE_CYC, width[1])
		`CHK("pos width", PULSE_CYC, width[2])
		$display("test trigger done");
		exp_q.push_back(sv[0]);
		run_start = 1;
		tick(1);
		run_start = 0;
		tick(50);
		run_abort = 1;
		tick(1);
		run_abort = 0;
		tick(5);
		`CHK("abort stops", 1'b0, running)
		`CHK("abort keeps step", 0, exp_q.size())
		$display("test abort done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
